// *** core/current_limit_lock_fault_handler.sv ***
/*
  Fault reaction for current-limit lock: deglitch, mode-dependent
  output override, auto retry with limit, fault pin, register port
  and interrupt. Assumes pwm inputs and retryLimit come from logic on
  mclk; currentAboveThr is asynchronous and is synchronised here.
*/
//
// Contract
// - Modes 0,1 latch fault, tristate outputs
// - Mode 2 latches fault, high-side brake
// - Mode 3 latches fault, low-side brake
// - Modes 4,5 tristate, auto clear, limited
// - Mode 6 high-side brake, auto clear, limited
// - Mode 7 low-side brake, auto clear, limited
// - Mode 8 reports only, gates untouched
// - Modes 9 to F disable detection
// - Deglitch field selects filter time
// - Retry field selects auto clear wait
// - Mode, deglitch, retry fields reset zero
`timescale 1ns/1ps
`default_nettype none
module current_limit_lock_fault_handler
  import lock_fault_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // Lock sensing and limits
  input wire logic currentAboveThr,
  input wire logic [CNT_W-1:0] retry_count_limit,
  // Gate commands from commutation
  input wire logic [2:0] pwmHsIn,
  input wire logic [2:0] pwmLsIn,
  // Gate driver
  output logic [2:0] gateHsOn,
  output logic [2:0] gateLsOn,
  output logic gateHiZ,
  // Fault and interrupt
  output logic fault_out_n,
  output logic irq
);

  initial begin
    if (TickCycles < 2 || TickCycles > 1048576) begin
      $error("current_limit_lock_fault_handler: TickCycles out of range");
    end
    // Longest waits must fit the shared timer width
    if ((RETRY_MS[15] * 1000) / TICK_US >= (1 << TMR_W)) begin
      $error("current_limit_lock_fault_handler: retry timer too narrow");
    end
    if (DEG_US[15] / TICK_US >= (1 << TMR_W)) begin
      $error("current_limit_lock_fault_handler: deglitch timer too narrow");
    end
    // Retry count read-back field is four bits wide
    if (CNT_W > 4) begin
      $error("current_limit_lock_fault_handler: retry counter too wide");
    end
    // Register offsets must be word aligned
    if (ADDR_SETTINGS[1:0] != 2'h0 || ADDR_STATUS[1:0] != 2'h0 ||
        ADDR_MASK[1:0] != 2'h0 || ADDR_CONTROL[1:0] != 2'h0) begin
      $error("current_limit_lock_fault_handler: register offsets not word aligned");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RETRY_WAIT, ST_LATCHED} state_t;

  // Registers
  logic [31:0] settings_q;
  logic [31:0] settings_d;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] status_d;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] mask_d;
  logic [31:0] rdData_q;
  state_t state_q;
  state_t state_d;
  action_t action_q;
  action_t action_d;
  logic [CNT_W-1:0] retryCnt_q;
  logic [CNT_W-1:0] retryCnt_d;
  logic [TMR_W-1:0] retryTmr_q;
  logic [TMR_W-1:0] retryTmr_d;
  logic [2:0] hs_q;
  logic [2:0] ls_q;
  logic hiZ_q;
  logic faultN_q;
  logic irq_q;
  logic syncA_q;
  logic syncB_q;

  // Field decode
  wire [3:0] modeSel = settings_q[MODE_MSB:MODE_LSB];
  wire [3:0] lock_deglitch_sel = settings_q[DEG_MSB:DEG_LSB];
  wire [3:0] lock_retry_time_sel = settings_q[RETRY_MSB:RETRY_LSB];

  // Address decode
  wire selSettings = (regAddr == ADDR_SETTINGS);
  wire selStatus = (regAddr == ADDR_STATUS);
  wire selMask = (regAddr == ADDR_MASK);
  wire selControl = (regAddr == ADDR_CONTROL);
  wire wrSettings = regWrEn && selSettings;
  wire wrStatus = regWrEn && selStatus;
  wire wrMask = regWrEn && selMask;
  wire hostClear = regWrEn && selControl && regWrData[CTL_CLEAR];

  // Over-threshold level, two-stage synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= currentAboveThr;
      syncB_q <= syncA_q;
    end
  end

  // Deglitch filter; its divider restarts while below threshold
  wire detEnable = modeEnabled(modeSel) && (state_q == ST_IDLE);
  wire degTick;
  wire lockPulse;

  tick_divider #(
    .Cycles(TickCycles)
  ) u_deg_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .restart(!(syncB_q && detEnable)),
    .tickEn(degTick)
  );

  lock_deglitch_filter u_filter (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable(detEnable),
    .aboveThr(syncB_q),
    .tickEn(degTick),
    .limitTicks(deglitchTicks(lock_deglitch_sel)),
    .lockPulse(lockPulse)
  );

  // Retry timer base, aligned to the moment the wait starts
  wire startRetry;
  wire retryTick;

  tick_divider #(
    .Cycles(TickCycles)
  ) u_retry_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .restart(startRetry),
    .tickEn(retryTick)
  );

  // Reaction decode for the lock just seen
  wire retryMode = modeRetries(modeSel);
  wire limitReached = (retryCnt_q >= retry_count_limit);
  wire goRetry = lockPulse && retryMode && !limitReached;
  wire goLatch = lockPulse && !goRetry;
  assign startRetry = (state_q == ST_IDLE) && goRetry;
  wire retryDone = (state_q == ST_RETRY_WAIT) && retryTick && (retryTmr_q <= TMR_W'(1));

  // Fault state machine
  always_comb begin
    state_d = state_q;
    action_d = action_q;
    retryCnt_d = retryCnt_q;
    retryTmr_d = retryTmr_q;
    unique case (state_q)
      ST_IDLE: begin
        if (hostClear) begin
          retryCnt_d = '0;
        end
        if (goRetry) begin
          state_d = ST_RETRY_WAIT;
          action_d = modeAction(modeSel);
          retryTmr_d = retryTicks(lock_retry_time_sel);
        end else if (goLatch) begin
          state_d = ST_LATCHED;
          action_d = modeAction(modeSel);
        end
      end
      ST_RETRY_WAIT: begin
        if (hostClear) begin
          state_d = ST_IDLE;
          action_d = ACT_NONE;
          retryCnt_d = '0;
        end else if (retryDone) begin
          state_d = ST_IDLE;
          action_d = ACT_NONE;
          retryCnt_d = retryCnt_q + CNT_W'(1);
        end else if (retryTick) begin
          retryTmr_d = retryTmr_q - TMR_W'(1);
        end
      end
      ST_LATCHED: begin
        if (hostClear) begin
          state_d = ST_IDLE;
          action_d = ACT_NONE;
          retryCnt_d = '0;
        end
      end
      // Unused code: fall back to a safe latched stop
      default: begin
        state_d = ST_LATCHED;
        action_d = ACT_TRISTATE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      action_q <= ACT_NONE;
    end else begin
      state_q <= state_d;
      action_q <= action_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      retryCnt_q <= '0;
      retryTmr_q <= '0;
    end else begin
      retryCnt_q <= retryCnt_d;
      retryTmr_q <= retryTmr_d;
    end
  end

  // Gate override; a report-only fault leaves the commands alone
  wire faultActive = (state_q != ST_IDLE);
  wire forceTri = faultActive && (action_q == ACT_TRISTATE);
  wire forceHs = faultActive && (action_q == ACT_HS_BRAKE);
  wire forceLs = faultActive && (action_q == ACT_LS_BRAKE);
  wire passCmd = !(forceTri || forceHs || forceLs);
  logic [2:0] hs_d;
  logic [2:0] ls_d;

  // Same override on every phase
  for (genvar ph = 0; ph < 3; ph++) begin : g_phase
    assign hs_d[ph] = forceHs || (passCmd && pwmHsIn[ph]);
    assign ls_d[ph] = forceLs || (passCmd && pwmLsIn[ph]);
  end

  // Registered outputs avoid glitches on the gate lines
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hs_q <= 3'h0;
      ls_q <= 3'h0;
      hiZ_q <= 1'b0;
    end else begin
      hs_q <= hs_d;
      ls_q <= ls_d;
      hiZ_q <= forceTri;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      faultN_q <= 1'b1;
    end else begin
      faultN_q <= !faultActive;
    end
  end

  assign gateHsOn = hs_q;
  assign gateLsOn = ls_q;
  assign gateHiZ = hiZ_q;
  assign fault_out_n = faultN_q;

  // Events; a set in the clearing cycle wins
  logic [EVT_W-1:0] events;
  assign events[EVT_LOCK] = lockPulse;
  assign events[EVT_AUTOCLR] = retryDone;
  assign events[EVT_LATCH] = goLatch;
  wire [EVT_W-1:0] w1c = wrStatus ? regWrData[EVT_W-1:0] : '0;
  for (genvar ev = 0; ev < EVT_W; ev++) begin : g_event
    assign status_d[ev] = events[ev] || (status_q[ev] && !w1c[ev]);
  end
  assign mask_d = wrMask ? regWrData[EVT_W-1:0] : mask_q;
  assign settings_d = wrSettings ? (regWrData & SETTINGS_WMASK) : settings_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      settings_q <= SETTINGS_RESET;
    end else begin
      settings_q <= settings_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= EVT_RESET;
      mask_q <= EVT_RESET;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  // Registered so the pin cannot glitch while status settles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  assign irq = irq_q;

  // Read side
  // Control read-back: fault, state, retry count, action
  wire [1:0] ctlState = 2'(state_q);
  wire [1:0] ctlAction = 2'(action_q);
  wire [31:0] controlView = {22'h00_0000, ctlAction, retryCnt_q, 1'b0, ctlState, faultActive};
  wire [31:0] rdMux = selSettings ? settings_q :
                      selStatus ? {29'h0000_0000, status_q} :
                      selMask ? {29'h0000_0000, mask_q} :
                      selControl ? controlView : 32'h0000_0000;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 32'h0000_0000;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end else begin
      rdData_q <= 32'h0000_0000;
    end
  end

  assign regRdData = rdData_q;

endmodule : current_limit_lock_fault_handler
`default_nettype wire

// *** core/lock_deglitch_filter.sv ***
/*
  Qualifies the over-threshold level: it must stay high for limitTicks
  ticks without a break. Assumes tickEn comes from a divider that is
  restarted whenever the level is low, so the time is exact.
*/
`timescale 1ns/1ps
`default_nettype none
module lock_deglitch_filter
  import lock_fault_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Level and timing
  input wire logic enable,
  input wire logic aboveThr,
  input wire logic tickEn,
  input wire logic [TMR_W-1:0] limitTicks,
  // Result
  output logic lockPulse
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic fired_q;
  logic fired_d;

  wire run = enable && aboveThr;
  wire reach = run && tickEn && !fired_q && (cnt_q + TMR_W'(1) >= limitTicks);

  // Any drop below threshold restarts the count
  assign cnt_d = !run ? '0 : (tickEn && !fired_q) ? cnt_q + TMR_W'(1) : cnt_q;
  // One report per continuous episode
  assign fired_d = run && (fired_q || reach);
  assign lockPulse = reach;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fired_q <= fired_d;
    end
  end

endmodule : lock_deglitch_filter
`default_nettype wire

// *** core/lock_fault_pkg.sv ***
/*
  Shared constants, types and decode functions for the current-limit
  lock fault handler: register map, field positions, timing tables.
  Assumes a single core clock at CLK_MHZ.
*/
package lock_fault_pkg;

  // Core clock and time base
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 50;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TMR_W = 20;
  localparam int CNT_W = 4;

  // Register map, byte addresses on the plain register port
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_SETTINGS = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h94;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h98;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h9C;

  // Settings register layout
  localparam int MODE_LSB = 15;
  localparam int MODE_MSB = 18;
  localparam int DEG_LSB = 11;
  localparam int DEG_MSB = 14;
  localparam int RETRY_LSB = 7;
  localparam int RETRY_MSB = 10;
  localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
  localparam logic [31:0] SETTINGS_WMASK = 32'h7FFF_FFFF;

  // Event status bits, shared by status and mask registers
  localparam int EVT_W = 3;
  localparam int EVT_LOCK = 0;
  localparam int EVT_AUTOCLR = 1;
  localparam int EVT_LATCH = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

  // Control register: write bit, read-back field positions
  localparam int CTL_CLEAR = 0;
  localparam int CTL_FAULT = 0;
  localparam int CTL_STATE_LSB = 1;
  localparam int CTL_CNT_LSB = 4;
  localparam int CTL_ACT_LSB = 8;

  // Lock reaction mode codes
  localparam logic [3:0] MODE_HS_LATCH = 4'h2;
  localparam logic [3:0] MODE_LS_LATCH = 4'h3;
  localparam logic [3:0] MODE_TRI_RETRY_A = 4'h4;
  localparam logic [3:0] MODE_TRI_RETRY_B = 4'h5;
  localparam logic [3:0] MODE_HS_RETRY = 4'h6;
  localparam logic [3:0] MODE_LS_RETRY = 4'h7;
  localparam logic [3:0] MODE_REPORT = 4'h8;

  typedef enum logic [1:0] {ACT_NONE, ACT_TRISTATE, ACT_HS_BRAKE, ACT_LS_BRAKE} action_t;

  // Filter times in microseconds, retry times in milliseconds
  localparam int DEG_US [16] = '{50, 100, 200, 500, 1000, 2500, 5000, 7500,
                                 10000, 25000, 50000, 75000, 100000, 200000,
                                 500000, 1000000};
  localparam int RETRY_MS [16] = '{300, 500, 1000, 2000, 3000, 4000, 5000, 6000,
                                   7000, 8000, 9000, 10000, 11000, 12000,
                                   13000, 14000};

  function automatic logic [TMR_W-1:0] deglitchTicks(input logic [3:0] sel);
    deglitchTicks = TMR_W'(DEG_US[sel] / TICK_US);
  endfunction : deglitchTicks

  function automatic logic [TMR_W-1:0] retryTicks(input logic [3:0] sel);
    retryTicks = TMR_W'((RETRY_MS[sel] * 1000) / TICK_US);
  endfunction : retryTicks

  function automatic logic modeEnabled(input logic [3:0] m);
    modeEnabled = (m <= MODE_REPORT);
  endfunction : modeEnabled

  function automatic logic modeRetries(input logic [3:0] m);
    modeRetries = (m >= MODE_TRI_RETRY_A) && (m <= MODE_LS_RETRY);
  endfunction : modeRetries

  function automatic action_t modeAction(input logic [3:0] m);
    if (m == MODE_REPORT) begin
      modeAction = ACT_NONE;
    end else if (m == MODE_HS_LATCH || m == MODE_HS_RETRY) begin
      modeAction = ACT_HS_BRAKE;
    end else if (m == MODE_LS_LATCH || m == MODE_LS_RETRY) begin
      modeAction = ACT_LS_BRAKE;
    end else begin
      modeAction = ACT_TRISTATE;
    end
  endfunction : modeAction

endpackage : lock_fault_pkg

// *** core/tick_divider.sv ***
/*
  Divider giving a one-cycle enable pulse every Cycles clocks.
  Assumes restart is synchronous to mclk; restart realigns the phase.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider
  import lock_fault_pkg::*;
#(
  parameter int Cycles = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control
  input wire logic restart,
  output logic tickEn
);

  initial begin
    if (Cycles < 2 || Cycles > 1048576) begin
      $error("tick_divider: Cycles out of range");
    end
  end

  localparam int DW = $clog2(Cycles);
  localparam logic [DW-1:0] LAST = DW'(Cycles - 1);

  logic [DW-1:0] cnt_q;
  logic [DW-1:0] cnt_d;
  wire atLast = (cnt_q == LAST);

  assign cnt_d = (restart || atLast) ? '0 : cnt_q + DW'(1);
  assign tickEn = atLast && !restart;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : tick_divider
`default_nettype wire

// *** tb/current_limit_lock_fault_handler_bench.sv ***
/* Bench: registers, mode sweep, retry runs, deglitch timing, interrupt.
   Assumes a tick of two clocks so retry waits stay short. */
`timescale 1ns/1ps
`default_nettype none
module current_limit_lock_fault_handler_bench
  import lock_fault_pkg::*;
;
  localparam int Tc = 2;
  logic mclk = 1'b0, arst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, stall = 1'b0;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [3:0] limit = 4'h0;
  logic [2:0] hs = 3'h0, ls = 3'h0, gateHsOn, gateLsOn;
  logic [31:0] regRdData, rd, r;
  logic gateHiZ, fault_out_n, irq, currentAboveThr, shootThrough;
  int mismatches = 0, tests_run = 0, seed = 24, n, exp;
  int codes[$] = '{0, 2, 3, 5};
  int rmodes[$] = '{4, 6, 7};

  current_limit_lock_fault_handler #(.TickCycles(Tc)) uut (
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .currentAboveThr(currentAboveThr), .retry_count_limit(limit),
    .pwmHsIn(hs), .pwmLsIn(ls), .gateHsOn(gateHsOn), .gateLsOn(gateLsOn),
    .gateHiZ(gateHiZ), .fault_out_n(fault_out_n), .irq(irq));
  motor_stage_model motor (.stall(stall), .gateHsOn(gateHsOn), .gateLsOn(gateLsOn),
    .gateHiZ(gateHiZ), .currentAboveThr(currentAboveThr), .shootThrough(shootThrough));

  function automatic int actOf(input int m);
    actOf = m > 7 ? 0 : (m == 2 || m == 6) ? 2 : (m == 3 || m == 7) ? 3 : 1;
  endfunction : actOf
  function automatic logic [6:0] gatesOf(input int a, input logic [5:0] p);
    gatesOf = a == 1 ? 7'h40 : a == 2 ? 7'h38 : a == 3 ? 7'h07 : {1'b0, p};
  endfunction : gatesOf

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rdReg(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1 rd = regRdData;
  endtask : rdReg
  task automatic waitPin(input logic lvl, input int lim, input logic must);
    n = 0;
    while (fault_out_n !== lvl && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    if (must && fault_out_n !== lvl) begin
      mismatches++;
      $display("[FAIL] %0t ns: fault pin wait ran out", $time);
      print_verdict;
    end
  endtask : waitPin
  task automatic clearAll;
    @(posedge mclk);
    stall <= 1'b0;
    wr(ADDR_CONTROL, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0007);
    #1 check(fault_out_n, 1'b1);
  endtask : clearAll

  initial begin
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    print_verdict;
  end

  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    for (int a = 8'h90; a <= 8'h9C; a += 4) begin
      rdReg(8'(a));
      check(rd, 32'h0000_0000);
    end
    rdReg(8'h40);
    check(rd, 32'h0000_0000);
    r = $random(seed);
    wr(ADDR_SETTINGS, r);
    rdReg(ADDR_SETTINGS);
    check(rd, r & 32'h7FFF_FFFF);
    $display("test registers done");
    // Limit zero: retry modes latch on first lock
    for (int m = 0; m < 16; m++) begin
      r = $random(seed);
      @(posedge mclk);
      hs <= r[2:0];
      ls <= r[5:3] & ~r[2:0];
      wr(ADDR_SETTINGS, 32'(m) << MODE_LSB);
      stall <= 1'b1;
      waitPin(1'b0, 40, m < 9);
      check(fault_out_n, m > 8);
      check({gateHiZ, gateHsOn, gateLsOn}, gatesOf(actOf(m), {hs, ls}));
      check({shootThrough, irq}, 2'b00);
      rdReg(ADDR_CONTROL);
      check({rd[9:8], rd[2:0]}, m < 9 ? {2'(actOf(m)), 3'h5} : 5'h00);
      rdReg(ADDR_STATUS);
      check(rd[2:0], m < 9 ? 3'h5 : 3'h0);
      clearAll;
    end
    $display("test modes done");
    @(posedge mclk);
    limit <= 4'h1;
    wr(ADDR_MASK, 32'h0000_0002);
    foreach (rmodes[i]) begin
      wr(ADDR_SETTINGS, 32'(rmodes[i]) << MODE_LSB);
      stall <= 1'b1;
      waitPin(1'b0, 40, 1'b1);
      rdReg(ADDR_CONTROL);
      check(rd[7:0], 8'h03);
      exp = RETRY_MS[0] * 1000 / TICK_US * Tc;
      waitPin(1'b1, exp + 100, 1'b1);
      check(n + 8 > exp && n < exp + 8, 1'b1);
      waitPin(1'b0, 40, 1'b1);
      rdReg(ADDR_CONTROL);
      check({rd[9:8], rd[7:0]}, {2'(actOf(rmodes[i])), 8'h15});
      check({irq, gateHiZ, gateHsOn, gateLsOn}, {1'b1, gatesOf(actOf(rmodes[i]), 6'h00)});
      clearAll;
      rdReg(ADDR_CONTROL);
      check({irq, rd[7:0]}, 9'h000);
    end
    $display("test retries done");
    @(posedge mclk);
    limit <= 4'h0;
    wr(ADDR_MASK, 32'h0000_0000);
    foreach (codes[i]) begin
      exp = DEG_US[codes[i]] / TICK_US * Tc;
      wr(ADDR_SETTINGS, 32'(codes[i]) << DEG_LSB);
      // A break halfway must restart the filter
      if (exp > 4) begin
        stall <= 1'b1;
        repeat (exp / 2) @(posedge mclk);
        stall <= 1'b0;
        waitPin(1'b0, exp + 10, 1'b0);
        check(fault_out_n, 1'b1);
      end
      @(posedge mclk);
      stall <= 1'b1;
      waitPin(1'b0, exp + 40, 1'b1);
      check(n > exp && n < exp + 8, 1'b1);
      clearAll;
    end
    $display("test deglitch done");
    print_verdict;
  end
endmodule : current_limit_lock_fault_handler_bench
`default_nettype wire

// *** tb/lock_fault_monitor.sv ***
/* Port checker for the lock fault handler, bound to every instance.
   Assumes pwm inputs stay quiet while reset is low. */
`timescale 1ns/1ps
`default_nettype none
module lock_fault_monitor
  import lock_fault_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  // Sensing and gates
  input wire logic currentAboveThr,
  input wire logic [2:0] pwmHsIn,
  input wire logic [2:0] pwmLsIn,
  input wire logic [2:0] gateHsOn,
  input wire logic [2:0] gateLsOn,
  input wire logic gateHiZ,
  input wire logic fault_out_n,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  wire logic mapped = regAddr inside {ADDR_SETTINGS, ADDR_STATUS, ADDR_MASK, ADDR_CONTROL};
  sequence hostClear;
    regWrEn && regAddr == ADDR_CONTROL && regWrData[CTL_CLEAR];
  endsequence
  sequence settingsRead;
    regRdEn && regAddr == ADDR_SETTINGS;
  endsequence
  rd_idle_zero_a: assert property (!$past(regRdEn) |-> regRdData == 32'h0000_0000)
    else $error("read data outside read slot");
  rd_unmapped_a: assert property (regRdEn && !mapped |=> regRdData == 32'h0000_0000)
    else $error("unmapped read not zero");
  rd_reserved_a: assert property (settingsRead |=> !regRdData[31])
    else $error("reserved settings bit reads one");
  hiz_gates_off_a: assert property (gateHiZ |-> gateHsOn == 3'h0 && gateLsOn == 3'h0)
    else $error("gates on while tristated");
  pass_through_a: assert property (fault_out_n |-> !gateHiZ && gateHsOn == $past(pwmHsIn) && gateLsOn == $past(pwmLsIn))
    else $error("gates altered without fault");
  hiz_fault_a: assert property ($rose(gateHiZ) |-> !fault_out_n)
    else $error("tristate without fault pin");
  // Sync plus filter plus output stage is at least five cycles
  lock_cause_a: assert property ($fell(fault_out_n) |-> $past(currentAboveThr, 4) && $past(currentAboveThr, 5))
    else $error("fault without held overcurrent");
  host_clear_a: assert property (hostClear |-> ##[1:3] fault_out_n)
    else $error("host clear left fault active");
  reset_quiet_a: assert property ($rose(arst_n) |-> fault_out_n && !irq && !gateHiZ)
    else $error("outputs not quiet after reset");
endmodule : lock_fault_monitor

bind current_limit_lock_fault_handler lock_fault_monitor mon (
  .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .currentAboveThr(currentAboveThr), .pwmHsIn(pwmHsIn), .pwmLsIn(pwmLsIn),
  .gateHsOn(gateHsOn), .gateLsOn(gateLsOn), .gateHiZ(gateHiZ),
  .fault_out_n(fault_out_n), .irq(irq)
);
`default_nettype wire

// *** tb/motor_stage_model.sv ***
/* Motor and bridge stand-in: current rises while the rotor is stalled
   and the bridge conducts. Assumes gate outputs come from the handler. */
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model (
  // Bench control
  input wire logic stall,
  // Gate commands
  input wire logic [2:0] gateHsOn,
  input wire logic [2:0] gateLsOn,
  input wire logic gateHiZ,
  // Sensing
  output logic currentAboveThr,
  output logic shootThrough
);
  // Tristated bridge carries no drive current
  assign currentAboveThr = stall && !gateHiZ;
  assign shootThrough = |(gateHsOn & gateLsOn);
endmodule : motor_stage_model
`default_nettype wire
